// *** hdl/sac_top.sv ***
// Converter control, start selection and result formatting
`timescale 1ns/1ps
`default_nettype none
module sac_top
   import sac_pkg::*;
(
   input  wire logic        core_clk_i,
   input  wire logic        rst_i,
   input  wire logic        converter_enable_i,
   input  wire logic [4:0]  positive_select_field_i,
   input  wire logic [4:0]  negative_input_select_i,
   input  wire logic [4:0]  conversion_clock_divider_i,
   input  wire logic        left_justify_select_i,
   input  wire logic [2:0]  start_source_select_i,
   input  wire logic        busy_write_one_i,
   input  wire logic [3:0]  timer_overflow_i,
   input  wire logic        external_start_input_i,
   input  wire logic        done_flag_clear_i,
   input  wire logic        done_int_enable_i,
   input  wire logic        sar_compare_i,
   output logic             converter_power_o,
   output sac_mux_t         input_multiplexer_o,
   output logic [9:0]       sar_trial_o,
   output logic             sar_sample_o,
   output logic             conversion_busy_o,
   output logic             conversion_done_flag_o,
   output logic             conversion_irq_o,
   output logic [7:0]       result_high_byte_o,
   output logic [7:0]       result_low_byte_o
);
   // -----------------------------------------------------------------
   // Declarations
   // -----------------------------------------------------------------
   sac_state_t  state_r, state_nxt;
   logic [1:0]  ext_sync_r;
   logic        ext_prev_r;
   logic        ext_rise;
   logic        start_req;
   logic        tick;
   logic [3:0]  tick_cnt_r, tick_cnt_nxt;
   logic [5:0]  cyc_cnt_r, cyc_cnt_nxt;
   logic [9:0]  sar_r, sar_nxt;
   logic [9:0]  bit_r, bit_nxt;
   logic        ljst_r;
   logic        se_r;
   logic        done_r;
   logic        conv_end;
   logic        done_set;
   sac_result_t result_r;
   sac_result_t fmt_res;
   logic        running;
   logic        pos_pin_ok;
   logic        neg_pin_ok;
   logic        se_mode;

   // Format a 10-bit word into the two result bytes
   function automatic sac_result_t fmt(input logic [9:0] w,
                                       input logic       ljst,
                                       input logic       se);
      sac_result_t r;
      r = '0;
      if (ljst) begin
         r = {w, 6'h00};
      end else if (se) begin
         r = {6'h00, w};
      end else begin
         r = {{6{w[9]}}, w};
      end
      return r;
   endfunction

   // -----------------------------------------------------------------
   // Input multiplexer decode
   // -----------------------------------------------------------------
   assign pos_pin_ok = positive_select_field_i <= SEL_PIN_LAST;
   assign neg_pin_ok = negative_input_select_i <= SEL_PIN_LAST;
   assign se_mode    = negative_input_select_i == NEG_GND;
   // Positive side: pins, sensor, supply
   assign input_multiplexer_o.pos_src =
      pos_pin_ok ? SAC_P_PIN :
      (positive_select_field_i == POS_TEMP) ? SAC_P_TEMP :
      (positive_select_field_i == POS_VDD)  ? SAC_P_VDD  : SAC_P_NONE;
   assign input_multiplexer_o.pos_pin = positive_select_field_i;
   // Negative side: pins, reference, ground
   assign input_multiplexer_o.neg_src =
      neg_pin_ok ? SAC_N_PIN :
      (negative_input_select_i == NEG_VREF) ? SAC_N_VREF :
      se_mode ? SAC_N_GND : SAC_N_NONE;
   assign input_multiplexer_o.neg_pin      = negative_input_select_i;
   assign input_multiplexer_o.single_ended = se_mode;

   // -----------------------------------------------------------------
   // Start source selection
   // -----------------------------------------------------------------
   assign ext_rise  = ext_sync_r[1] && !ext_prev_r;
   assign start_req =
      (start_source_select_i == SRC_SOFT) ? busy_write_one_i :
      (start_source_select_i == SRC_TMR0) ? timer_overflow_i[0] :
      (start_source_select_i == SRC_TMR1) ? timer_overflow_i[1] :
      (start_source_select_i == SRC_TMR2) ? timer_overflow_i[2] :
      (start_source_select_i == SRC_TMR3) ? timer_overflow_i[3] :
      (start_source_select_i == SRC_EXT)  ? ext_rise : 1'b0;

   // Synchronise the external start pin
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         ext_sync_r <= 2'b00;
         ext_prev_r <= 1'b0;
      end else begin
         ext_sync_r <= {ext_sync_r[0], external_start_input_i};
         ext_prev_r <= ext_sync_r[1];
      end
   end

   // -----------------------------------------------------------------
   // Conversion clock
   // -----------------------------------------------------------------
   assign running = (state_r == SAC_CONV);
   sac_clkdiv u_div (
      .core_clk_i (core_clk_i),
      .rst_i      (rst_i),
      .run_i      (running),
      .div_i      (conversion_clock_divider_i),
      .tick_o     (tick)
   );

   // -----------------------------------------------------------------
   // Sequencer
   // -----------------------------------------------------------------
   // Ends after all SAR ticks and the minimum conversion period
   assign conv_end = running && (tick_cnt_r == SAR_TICKS)
                     && (cyc_cnt_r >= MIN_CONV_CNT);
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         SAC_OFF: begin
            if (converter_enable_i) begin
               state_nxt = SAC_IDLE;
            end
         end
         SAC_IDLE: begin
            if (!converter_enable_i) begin
               state_nxt = SAC_OFF;
            end else if (start_req) begin
               state_nxt = SAC_CONV;
            end
         end
         SAC_CONV: begin
            if (!converter_enable_i) begin
               state_nxt = SAC_OFF;
            end else if (conv_end) begin
               state_nxt = SAC_IDLE;
            end
         end
         default: state_nxt = SAC_OFF;
      endcase
   end

   // Counters and successive approximation
   always_comb begin
      tick_cnt_nxt = tick_cnt_r;
      cyc_cnt_nxt  = cyc_cnt_r;
      sar_nxt      = sar_r;
      bit_nxt      = bit_r;
      if (state_nxt == SAC_CONV && !running) begin
         tick_cnt_nxt = 4'h0;
         cyc_cnt_nxt  = 6'h00;
         sar_nxt      = 10'h000;
         bit_nxt      = 10'h200;
      end else if (running) begin
         if (cyc_cnt_r < MIN_CONV_CNT) begin
            cyc_cnt_nxt = cyc_cnt_r + 6'h01;
         end
         if (tick && tick_cnt_r < SAR_TICKS) begin
            tick_cnt_nxt = tick_cnt_r + 4'h1;
            if (tick_cnt_r >= 4'h2 && bit_r != 10'h000) begin
               sar_nxt = sar_compare_i ? (sar_r | bit_r) : sar_r;
               bit_nxt = bit_r >> 1;
            end
         end
      end
   end
   // Trial word: differential results are stored two's complement
   assign sar_trial_o  = sar_r | bit_r;
   assign sar_sample_o = running && (tick_cnt_r < 4'h2);
   assign fmt_res      = fmt(se_r ? sar_r : {~sar_r[9], sar_r[8:0]},
                             ljst_r, se_r);
   assign done_set     = conv_end;

   // State registers
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         state_r    <= SAC_OFF;
         tick_cnt_r <= 4'h0;
         cyc_cnt_r  <= 6'h00;
         sar_r      <= 10'h000;
         bit_r      <= 10'h000;
      end else begin
         state_r    <= state_nxt;
         tick_cnt_r <= tick_cnt_nxt;
         cyc_cnt_r  <= cyc_cnt_nxt;
         sar_r      <= sar_nxt;
         bit_r      <= bit_nxt;
      end
   end

   // Latch format controls at start
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         ljst_r <= 1'b0;
         se_r   <= 1'b0;
      end else if (state_nxt == SAC_CONV && !running) begin
         ljst_r <= left_justify_select_i;
         se_r   <= se_mode;
      end
   end

   // Result and done flag; a set beats a clear
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         result_r <= RESULT_RST;
         done_r   <= 1'b0;
      end else begin
         if (conv_end) begin
            result_r <= fmt_res;
         end
         if (done_set) begin
            done_r <= 1'b1;
         end else if (done_flag_clear_i) begin
            done_r <= 1'b0;
         end
      end
   end

   // -----------------------------------------------------------------
   // Outputs
   // -----------------------------------------------------------------
   assign converter_power_o      = (state_r != SAC_OFF);
   assign conversion_busy_o      = running;
   assign conversion_done_flag_o = done_r;
   assign conversion_irq_o       = done_r && done_int_enable_i;
   assign result_high_byte_o     = result_r.high_byte;
   assign result_low_byte_o      = result_r.low_byte;

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   a_off_no_busy: assert property (@(posedge core_clk_i) disable iff (rst_i)
      !converter_enable_i |=> !conversion_busy_o)
      else $error("busy while disabled");
   a_mode_decode: assert property (@(posedge core_clk_i) disable iff (rst_i)
      input_multiplexer_o.single_ended ==
      (negative_input_select_i == 5'h1f))
      else $error("mode decode wrong");
   a_busy_fall_done: assert property (@(posedge core_clk_i)
      disable iff (rst_i)
      $fell(conversion_busy_o) && converter_enable_i
      |-> conversion_done_flag_o)
      else $error("done not set on busy fall");
   a_result_hold: assert property (@(posedge core_clk_i) disable iff (rst_i)
      !$past(conv_end) |-> $stable(result_r))
      else $error("result changed without completion");
   a_min_period: assert property (@(posedge core_clk_i) disable iff (rst_i)
      $rose(conversion_busy_o) |-> conversion_busy_o [*8])
      else $error("conversion too short");
   a_se_zero_high: assert property (@(posedge core_clk_i) disable iff (rst_i)
      $past(conv_end) && se_r && !ljst_r
      |-> result_high_byte_o[7:2] == 6'h00)
      else $error("single-ended high bits not zero");
   a_sign_ext: assert property (@(posedge core_clk_i) disable iff (rst_i)
      $past(conv_end) && !se_r && !ljst_r
      |-> result_high_byte_o[7:2] == {6{result_high_byte_o[1]}})
      else $error("sign extension wrong");
   a_left_low_zero: assert property (@(posedge core_clk_i)
      disable iff (rst_i)
      $past(conv_end) && ljst_r
      |-> result_low_byte_o[5:0] == 6'h00)
      else $error("left-justified low bits not zero");
   a_soft_start: assert property (@(posedge core_clk_i) disable iff (rst_i)
      state_r == SAC_IDLE && converter_enable_i && busy_write_one_i
      && start_source_select_i == 3'h0 |=> conversion_busy_o)
      else $error("software start ignored");
endmodule
`default_nettype wire

// *** hdl/sac_pkg.sv ***
// Package of constants and types for the converter control block
//
// Behaviour
// - Converter runs only while enable is set
// - Two selectors give 19 inputs each: 17 pins plus two internal
// - Positive: port pins, temperature sensor, supply
// - Negative: port pins, reference, ground
// - Ground negative means single-ended, else differential
// - Completion loads high and low result bytes
// - Justify bit 0 right, 1 left
// - Single-ended codes are 10-bit unsigned
// - Single-ended unused bits zero; full scale 03ff right-justified, ffc0 left-justified
// - Differential codes are 10-bit two's complement
// - Right-justified differential high byte sign-extends
// - Left-justified differential low bits are zero
// - Throughput never above 200 ksps
// - Conversion clock is system clock over divider+1
// - Three-bit field picks one of six sources
// - Sensor select routes sensor to positive input
// - Sources: busy write, timers 0-3, external edge
// - Busy high while converting; fall at completion sets done flag, an abort by disable does not
// - Negative 11111 ground, 11110 reference
package sac_pkg;
   // -----------------------------------------------------------------
   // Timing
   // -----------------------------------------------------------------
   localparam int unsigned CLK_HZ         = 10000000;
   localparam int unsigned MAX_SPS        = 200000;
   localparam int unsigned MIN_CONV_CYC   = (CLK_HZ + MAX_SPS - 1) / MAX_SPS;
   localparam logic [5:0]  MIN_CONV_CNT   = MIN_CONV_CYC[5:0];
   localparam logic [3:0]  SAR_BITS       = 4'ha;
   localparam logic [3:0]  SAR_TICKS      = 4'hc;
   // -----------------------------------------------------------------
   // Selection codes
   // -----------------------------------------------------------------
   localparam logic [4:0]  SEL_PIN_LAST   = 5'h10;
   localparam logic [4:0]  POS_TEMP       = 5'h1e;
   localparam logic [4:0]  POS_VDD        = 5'h1f;
   localparam logic [4:0]  NEG_VREF       = 5'h1e;
   localparam logic [4:0]  NEG_GND        = 5'h1f;
   // -----------------------------------------------------------------
   // Start sources
   // -----------------------------------------------------------------
   localparam logic [2:0]  SRC_SOFT       = 3'h0;
   localparam logic [2:0]  SRC_TMR0       = 3'h1;
   localparam logic [2:0]  SRC_TMR2       = 3'h2;
   localparam logic [2:0]  SRC_TMR1       = 3'h3;
   localparam logic [2:0]  SRC_EXT        = 3'h4;
   localparam logic [2:0]  SRC_TMR3       = 3'h5;
   // -----------------------------------------------------------------
   // Reset values
   // -----------------------------------------------------------------
   localparam logic [4:0]  DIV_RST        = 5'h1f;
   localparam logic [15:0] RESULT_RST     = 16'h0000;
   // Analog routing to the converter core
   typedef enum logic [1:0] {
      SAC_P_PIN  = 2'h0,
      SAC_P_TEMP = 2'h1,
      SAC_P_VDD  = 2'h2,
      SAC_P_NONE = 2'h3
   } sac_pos_src_t;
   typedef enum logic [1:0] {
      SAC_N_PIN  = 2'h0,
      SAC_N_VREF = 2'h1,
      SAC_N_GND  = 2'h2,
      SAC_N_NONE = 2'h3
   } sac_neg_src_t;
   typedef struct packed {
      sac_pos_src_t pos_src;
      logic [4:0]   pos_pin;
      sac_neg_src_t neg_src;
      logic [4:0]   neg_pin;
      logic         single_ended;
   } sac_mux_t;
   typedef struct packed {
      logic [7:0] high_byte;
      logic [7:0] low_byte;
   } sac_result_t;
   typedef enum logic [2:0] {
      SAC_OFF  = 3'b001,
      SAC_IDLE = 3'b010,
      SAC_CONV = 3'b100
   } sac_state_t;
endpackage

// *** hdl/sac_clkdiv.sv ***
// Conversion clock divider producing one-cycle ticks
`timescale 1ns/1ps
`default_nettype none
module sac_clkdiv
   import sac_pkg::*;
(
   input  wire logic       core_clk_i,
   input  wire logic       rst_i,
   input  wire logic       run_i,
   input  wire logic [4:0] div_i,
   output logic            tick_o
);
   logic [4:0] cnt_r;
   logic [4:0] cnt_nxt;
   // -----------------------------------------------------------------
   // Divide by value plus one
   // -----------------------------------------------------------------
   assign tick_o  = run_i && (cnt_r >= div_i);
   assign cnt_nxt = (!run_i || tick_o) ? 5'h00 : cnt_r + 5'h01;
   // Counter
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         cnt_r <= 5'h00;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end
   // Tick spacing assertion: no back-to-back ticks unless dividing by one
   a_tick_period: assert property (@(posedge core_clk_i) disable iff (rst_i)
      tick_o && run_i ##1 run_i && $stable(div_i) && div_i != 5'h00
      |-> !tick_o)
      else $error("divider tick too early");
endmodule
`default_nettype wire

// *** sim/sac_top_tb_top.sv ***
// Self-checking bench for the converter control and result formatter
`timescale 1ns/1ps
`default_nettype none
module sac_top_tb_top
   import sac_pkg::*;
;
   // ----------------------------------------------------------------
   // Stimulus and observed signals
   // ----------------------------------------------------------------
   logic        core_clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        converter_enable_i = 1'b0;
   logic [4:0]  positive_select_field_i = 5'h00;
   logic [4:0]  negative_input_select_i = NEG_GND;
   logic [4:0]  conversion_clock_divider_i = 5'h00;
   logic        left_justify_select_i = 1'b0;
   logic [2:0]  start_source_select_i = SRC_SOFT;
   logic        busy_write_one_i = 1'b0;
   logic [3:0]  timer_overflow_i = 4'h0;
   logic        external_start_input_i = 1'b0;
   logic        done_flag_clear_i = 1'b0;
   logic        done_int_enable_i = 1'b1;
   logic        sar_compare_i;
   logic [9:0]  ain = 10'h000;
   logic        converter_power_o;
   sac_mux_t    input_multiplexer_o;
   logic [9:0]  sar_trial_o;
   logic        sar_sample_o;
   logic        conversion_busy_o;
   logic        conversion_done_flag_o;
   logic        conversion_irq_o;
   logic [7:0]  result_high_byte_o;
   logic [7:0]  result_low_byte_o;
   int          n_fail = 0;
   int          check_count = 0;
   int          cycles = 0;
   // Comparator stands in for the analog input held at ain
   assign sar_compare_i = (ain >= sar_trial_o);
   always #50 core_clk_i = ~core_clk_i;
   sac_top DUT (
      .core_clk_i                 (core_clk_i),
      .rst_i                      (rst_i),
      .converter_enable_i         (converter_enable_i),
      .positive_select_field_i    (positive_select_field_i),
      .negative_input_select_i    (negative_input_select_i),
      .conversion_clock_divider_i (conversion_clock_divider_i),
      .left_justify_select_i      (left_justify_select_i),
      .start_source_select_i      (start_source_select_i),
      .busy_write_one_i           (busy_write_one_i),
      .timer_overflow_i           (timer_overflow_i),
      .external_start_input_i     (external_start_input_i),
      .done_flag_clear_i          (done_flag_clear_i),
      .done_int_enable_i          (done_int_enable_i),
      .sar_compare_i              (sar_compare_i),
      .converter_power_o          (converter_power_o),
      .input_multiplexer_o        (input_multiplexer_o),
      .sar_trial_o                (sar_trial_o),
      .sar_sample_o               (sar_sample_o),
      .conversion_busy_o          (conversion_busy_o),
      .conversion_done_flag_o     (conversion_done_flag_o),
      .conversion_irq_o           (conversion_irq_o),
      .result_high_byte_o         (result_high_byte_o),
      .result_low_byte_o          (result_low_byte_o)
   );
   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk_i);
      #1;
   endtask
   task automatic chk(input string nm, input logic [15:0] e,
                      input logic [15:0] g);
      check_count++;
      if (g !== e) begin
         $display("wrong value %s: expected %h seen %h", nm, e, g);
         n_fail++;
      end
   endtask
   // Waits for busy to reach a level and reports the cycles taken
   task automatic wait_lvl(input logic lvl, input int lim, output int k);
      k = 0;
      while (conversion_busy_o !== lvl && k < lim) begin
         cyc(1);
         k++;
      end
      chk("busy level", {15'h0, lvl}, {15'h0, conversion_busy_o});
   endtask
   // Pulses whichever source a start code listens to
   task automatic fire(input logic [2:0] code);
      case (code)
         SRC_SOFT: busy_write_one_i = 1'b1;
         SRC_TMR0: timer_overflow_i = 4'h1;
         SRC_TMR1: timer_overflow_i = 4'h2;
         SRC_TMR2: timer_overflow_i = 4'h4;
         SRC_TMR3: timer_overflow_i = 4'h8;
         default:  external_start_input_i = 1'b1;
      endcase
      cyc(1);
      busy_write_one_i = 1'b0;
      timer_overflow_i = 4'h0;
      if (code == SRC_EXT) begin
         cyc(2);
         external_start_input_i = 1'b0;
      end
   endtask
   task automatic conv(input logic [9:0] v, output logic [15:0] r,
                       output int len);
      int k;
      ain = v;
      fire(start_source_select_i);
      wait_lvl(1'b1, 8, k);
      wait_lvl(1'b0, 2000, len);
      r = {result_high_byte_o, result_low_byte_o};
   endtask
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_format();
      logic [4:0]  ns [6] = '{5'h1f, 5'h1f, 5'h1f, 5'h1e, 5'h1e, 5'h1e};
      logic        lj [6] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
      logic [9:0]  v  [6] = '{10'h3ff, 10'h3ff, 10'h200, 10'h000,
                              10'h3ff, 10'h0ff};
      logic [15:0] ex [6] = '{16'h03ff, 16'hffc0, 16'h0200, 16'hfe00,
                              16'h7fc0, 16'hfeff};
      logic [15:0] r;
      int          len;
      for (int i = 0; i < 6; i++) begin
         negative_input_select_i = ns[i];
         left_justify_select_i = lj[i];
         conv(v[i], r, len);
         chk("result", ex[i], r);
         chk("done", 16'h1, {15'h0, conversion_done_flag_o});
         chk("irq", 16'h1, {15'h0, conversion_irq_o});
         done_flag_clear_i = 1'b1;
         cyc(1);
         done_flag_clear_i = 1'b0;
         chk("done clear", 16'h0, {15'h0, conversion_done_flag_o});
      end
      negative_input_select_i = NEG_GND;
      left_justify_select_i = 1'b0;
      $display("test format done");
   endtask
   task automatic t_mux();
      logic [4:0] ps [3] = '{POS_TEMP, POS_VDD, 5'h05};
      logic [4:0] ns [3] = '{NEG_GND, NEG_VREF, SEL_PIN_LAST};
      logic [1:0] pe [3] = '{SAC_P_TEMP, SAC_P_VDD, SAC_P_PIN};
      logic [1:0] ne [3] = '{SAC_N_GND, SAC_N_VREF, SAC_N_PIN};
      for (int i = 0; i < 3; i++) begin
         positive_select_field_i = ps[i];
         negative_input_select_i = ns[i];
         cyc(1);
         chk("pos src", {14'h0, pe[i]}, {14'h0, input_multiplexer_o.pos_src});
         chk("neg src", {14'h0, ne[i]}, {14'h0, input_multiplexer_o.neg_src});
         chk("single", {15'h0, i == 0}, {15'h0, input_multiplexer_o.single_ended});
      end
      chk("pin", 16'h0005, {11'h0, input_multiplexer_o.pos_pin});
      chk("neg pin", 16'h0010, {11'h0, input_multiplexer_o.neg_pin});
      negative_input_select_i = NEG_GND;
      $display("test mux done");
   endtask
   task automatic t_sources();
      logic [15:0] r;
      int          len;
      for (int c = 0; c < 6; c++) begin
         start_source_select_i = 3'(c);
         fire(c == 0 ? SRC_TMR0 : SRC_SOFT);
         cyc(4);
         chk("foreign start", 16'h0, {15'h0, conversion_busy_o});
         conv(10'h155, r, len);
         chk("source result", 16'h0155, r);
      end
      // Unused source code must never start a conversion
      start_source_select_i = 3'h6;
      fire(SRC_SOFT);
      cyc(4);
      chk("no source", 16'h0, {15'h0, conversion_busy_o});
      start_source_select_i = SRC_SOFT;
      $display("test sources done");
   endtask
   task automatic t_timing();
      logic [15:0] r;
      int          len;
      conv(10'h001, r, len);
      chk("min length", 16'h1, {15'h0, len >= int'(MIN_CONV_CYC) - 1});
      conversion_clock_divider_i = 5'h09;
      conv(10'h2aa, r, len);
      chk("div length", 16'h1, {15'h0, len >= 110 && len <= 134});
      chk("div result", 16'h02aa, r);
      conversion_clock_divider_i = 5'h00;
      $display("test timing done");
   endtask
   task automatic t_hold_abort();
      logic [15:0] r;
      int          len;
      int          k;
      done_int_enable_i = 1'b0;
      ain = 10'h3ff;
      fire(SRC_SOFT);
      chk("sample on", 16'h1, {15'h0, sar_sample_o});
      cyc(3);
      chk("sample off", 16'h0, {15'h0, sar_sample_o});
      left_justify_select_i = 1'b1;
      wait_lvl(1'b0, 2000, len);
      r = {result_high_byte_o, result_low_byte_o};
      chk("justify latched", 16'h03ff, r);
      chk("irq gated", 16'h0, {15'h0, conversion_irq_o});
      ain = 10'h000;
      cyc(20);
      chk("result hold", 16'h03ff, {result_high_byte_o, result_low_byte_o});
      done_flag_clear_i = 1'b1;
      cyc(1);
      done_flag_clear_i = 1'b0;
      fire(SRC_SOFT);
      cyc(5);
      converter_enable_i = 1'b0;
      cyc(2);
      chk("abort busy", 16'h0, {15'h0, conversion_busy_o});
      chk("abort power", 16'h0, {15'h0, converter_power_o});
      fire(SRC_SOFT);
      cyc(60);
      chk("no done", 16'h0, {15'h0, conversion_done_flag_o});
      chk("abort hold", 16'h03ff, {result_high_byte_o, result_low_byte_o});
      converter_enable_i = 1'b1;
      done_int_enable_i = 1'b1;
      left_justify_select_i = 1'b0;
      cyc(2);
      chk("power back", 16'h1, {15'h0, converter_power_o});
      $display("test hold_abort done");
   endtask
   // ----------------------------------------------------------------
   // Hang guard and main sequence
   // ----------------------------------------------------------------
   always @(posedge core_clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         n_fail++;
         give_verdict();
      end
   end
   initial begin
      cyc(3);
      rst_i = 1'b0;
      chk("reset result", RESULT_RST, {result_high_byte_o, result_low_byte_o});
      chk("reset power", 16'h0, {15'h0, converter_power_o});
      converter_enable_i = 1'b1;
      cyc(2);
      chk("power on", 16'h1, {15'h0, converter_power_o});
      $display("test reset done");
      t_mux();
      t_format();
      t_sources();
      t_timing();
      t_hold_abort();
      give_verdict();
   end
endmodule
`default_nettype wire
